// File: verilog/rss_pkg.sv
// Constants and types for the reset source and supply monitor sequencer
// Contract
// - Reset halts core, loads register defaults
// - Data memory kept; stack pointer reset (core state here has neither)
// - Port latches all ones, open-drain, pullups on
// - Power and supply resets drive pin low
// - Exit: program counter cleared, internal oscillator
// - Exit: watchdog on, clock divided by twelve
// - Every reset fetches from address zero
// - Power-up waits threshold, then release delay
// - Power-on exit sets power-on flag
// - Other resets clear the power-on flag
// - Power-on enables both supply monitors
// - Supply below threshold holds reset, drives pin
// - Standard monitor state survives non-power resets
// - Level monitor always an active source
// - Unprotected flash write causes flash-error reset
// - Supply reset releases without power-on delay
package rss_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int POR_DELAY_US  = 100;
    localparam int POR_DELAY_CYC = (POR_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int PULSE_NS      = 100;
    localparam int PULSE_CYC     =
        (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register map, byte addresses
    localparam int         ADDR_W     = 8;
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_CAUSE = 8'h04;

    // Field positions of supply_monitor_ctrl
    localparam int CTRL_EN_BIT   = 7;
    localparam int CTRL_STAT_BIT = 6;
    localparam int CTRL_HI_BIT   = 5;
    localparam int CTRL_LVL_BIT  = 4;
    // Field positions of reset_cause_reg
    localparam int CAUSE_POR_BIT = 1;
    localparam int CAUSE_SW_BIT  = 4;
    localparam int CAUSE_FLE_BIT = 6;

    // Bus answers
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        ST_POR_WAIT  = 3'b000,
        ST_POR_DELAY = 3'b001,
        ST_RUN       = 3'b010,
        ST_HOLD      = 3'b011,
        ST_PULSE     = 3'b100
    } rss_state_t;

    // State handed to the core and its peripherals
    typedef struct packed {
        logic        core_run;
        logic        pc_clear;
        logic [15:0] fetch_addr;
        logic        int_osc_sel;
        logic        wdt_en;
        logic [3:0]  wdt_div;
        logic        irq_tmr_off;
        logic [7:0]  port_latch;
        logic        port_od;
        logic        weak_pullup;
    } rss_core_t;

    localparam rss_core_t CORE_RST = '{
        core_run: 1'b0, pc_clear: 1'b1, fetch_addr: 16'h0000,
        int_osc_sel: 1'b1, wdt_en: 1'b1, wdt_div: 4'hc,
        irq_tmr_off: 1'b1, port_latch: 8'hff, port_od: 1'b1,
        weak_pullup: 1'b1};

endpackage

// File: verilog/rss_reset_seq.sv
// Reset sequencer with supply monitors and an AXI4-Lite register slave
`timescale 1ns/10ps
module rss_reset_seq import rss_pkg::*; #(
    parameter int POR_CYC = POR_DELAY_CYC,
    parameter int CNT_W   = 16
) (
    // Clock and power-on reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Supply monitor comparators, asynchronous
    input  wire logic              std_vdd_ok,
    input  wire logic              lvl_vdd_ok,
    // Monitor controls to the analog side
    output logic                   std_mon_en,
    output logic                   std_hi_sel,
    output logic                   lvl_mon_en,
    // Core side
    input  wire logic              flash_req,
    output rss_core_t              core,
    // Reset pin, open drain
    output logic                   rst_pin_o,
    output logic                   rst_pin_oe,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready
);

    localparam logic [CNT_W-1:0] POR_LOAD = CNT_W'(POR_CYC - 1);
    localparam logic [CNT_W-1:0] PUL_LOAD = CNT_W'(PULSE_CYC - 1);

    rss_state_t        state;
    logic [CNT_W-1:0]  cnt;
    logic [1:0]        std_sync;
    logic [1:0]        lvl_sync;
    logic              std_sel;
    logic              por_flag;
    logic              sw_flag;
    logic              fle_flag;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0]        w_byte;
    logic              w_lane;
    logic              wr_go;
    logic              wr_ctrl;
    logic              wr_cause;
    logic              supply_bad;
    logic              flash_err;
    logic              sw_rst;

    // Two flops before any logic sees the comparators
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            std_sync <= 2'h0;
            lvl_sync <= 2'h0;
        end else begin
            std_sync <= {std_sync[0], std_vdd_ok};
            lvl_sync <= {lvl_sync[0], lvl_vdd_ok};
        end
    end

    // Reset sources; level monitor cannot be masked
    assign supply_bad = ~lvl_sync[1]
                      | (std_mon_en & std_sel & ~std_sync[1]);
    assign flash_err  = flash_req & (state == ST_RUN)
                      & ~(std_mon_en & std_hi_sel & std_sel);
    assign wr_go      = ~awready & ~wready & ~bvalid;
    assign wr_ctrl    = wr_go & w_lane & (aw_addr == ADDR_CTRL);
    assign wr_cause   = wr_go & w_lane & (aw_addr == ADDR_CAUSE);
    assign sw_rst     = wr_cause & w_byte[CAUSE_SW_BIT] & (state == ST_RUN);

    // Sequencer; release only ever on a clock edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_POR_WAIT;
            cnt   <= '0;
        end else begin
            case (state)
                ST_POR_WAIT: begin
                    if (!supply_bad) begin
                        state <= ST_POR_DELAY;
                        cnt   <= POR_LOAD;
                    end
                end
                ST_POR_DELAY: begin
                    if (supply_bad) begin
                        state <= ST_POR_WAIT;
                    end else if (cnt == '0) begin
                        state <= ST_RUN;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                ST_RUN: begin
                    if (supply_bad) begin
                        state <= ST_HOLD;
                    end else if (flash_err || sw_rst) begin
                        state <= ST_PULSE;
                        cnt   <= PUL_LOAD;
                    end
                end
                ST_HOLD: begin
                    if (!supply_bad) begin
                        state <= ST_RUN;
                    end
                end
                ST_PULSE: begin
                    if (supply_bad) begin
                        state <= ST_HOLD;
                    end else if (cnt == '0) begin
                        state <= ST_RUN;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: state <= ST_POR_WAIT;
            endcase
        end
    end

    // Cause flags; only power-on sets the power-on flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            por_flag <= 1'b0;
            sw_flag  <= 1'b0;
            fle_flag <= 1'b0;
        end else if (state == ST_POR_DELAY && !supply_bad
                     && cnt == '0) begin
            por_flag <= 1'b1;
            sw_flag  <= 1'b0;
            fle_flag <= 1'b0;
        end else if (state == ST_RUN && (supply_bad || flash_err
                                         || sw_rst)) begin
            por_flag <= 1'b0;
            sw_flag  <= sw_rst & ~supply_bad & ~flash_err;
            fle_flag <= flash_err & ~supply_bad;
        end
    end

    // Standard monitor enable and select survive internal resets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            std_mon_en <= 1'b1;
            std_sel    <= 1'b1;
        end else begin
            if (wr_ctrl) begin
                std_mon_en <= w_byte[CTRL_EN_BIT];
            end
            if (wr_cause) begin
                std_sel <= w_byte[CAUSE_POR_BIT];
            end
        end
    end

    // Threshold select is an ordinary register: back to low on reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            std_hi_sel <= 1'b0;
            lvl_mon_en <= 1'b0;
        end else begin
            lvl_mon_en <= 1'b1;
            if (state != ST_RUN) begin
                std_hi_sel <= 1'b0;
            end else if (wr_ctrl) begin
                std_hi_sel <= w_byte[CTRL_HI_BIT];
            end
        end
    end

    // Core state; every field reloads CORE_RST whenever not running
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core <= CORE_RST;
        end else if (state != ST_RUN) begin
            core <= CORE_RST;
        end else begin
            core.core_run    <= 1'b1;
            core.pc_clear    <= 1'b0;
            core.irq_tmr_off <= 1'b0;
        end
    end

    // Pin pulled low for power-on and supply resets only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rst_pin_o  <= 1'b0;
            rst_pin_oe <= 1'b1;
        end else begin
            rst_pin_o  <= 1'b0;
            rst_pin_oe <= (state == ST_POR_WAIT) || (state == ST_POR_DELAY)
                        || (state == ST_HOLD);
        end
    end

    // Write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            aw_addr <= '0;
            w_byte  <= 8'h00;
            w_lane  <= 1'b0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_addr <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_byte <= wdata[7:0];
                w_lane <= wstrb[0];
            end
            if (bvalid && bready) begin
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Write response once both halves are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= (aw_addr == ADDR_CTRL || aw_addr == ADDR_CAUSE)
                    ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read channel, answer one cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= 32'h0000_0000;
            rresp   <= RESP_OKAY;
            if (araddr == ADDR_CTRL) begin
                rdata[CTRL_EN_BIT]   <= std_mon_en;
                rdata[CTRL_STAT_BIT] <= std_sync[1];
                rdata[CTRL_HI_BIT]   <= std_hi_sel;
                rdata[CTRL_LVL_BIT]  <= lvl_mon_en;
            end else if (araddr == ADDR_CAUSE) begin
                rdata[CAUSE_POR_BIT] <= por_flag;
                rdata[CAUSE_SW_BIT]  <= sw_flag;
                rdata[CAUSE_FLE_BIT] <= fle_flag;
            end else begin
                rresp <= RESP_SLVERR;
            end
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Supply trouble reaches the core within two edges
    property p_supply_hold;
        supply_bad |-> ##2 !core.core_run;
    endproperty
    a_supply_hold: assert property (p_supply_hold)
        else $error("core ran with supply low");
    property p_lvl_src;
        !lvl_sync[1] && !std_mon_en |-> ##2 !core.core_run;
    endproperty
    a_lvl_src: assert property (p_lvl_src)
        else $error("level monitor did not hold reset");
    property p_no_delay;
        state == ST_HOLD && !supply_bad |=> state == ST_RUN;
    endproperty
    a_no_delay: assert property (p_no_delay)
        else $error("supply reset release was delayed");
    property p_por_release;
        state == ST_POR_DELAY && cnt == '0 && !supply_bad
            |=> state == ST_RUN ##1 core.core_run;
    endproperty
    a_por_release: assert property (p_por_release)
        else $error("power-on release missed");
    property p_por_flag;
        state == ST_POR_DELAY ##1 state == ST_RUN |-> por_flag;
    endproperty
    a_por_flag: assert property (p_por_flag)
        else $error("power-on flag not set");
    property p_flag_clr;
        state == ST_RUN ##1 (state == ST_HOLD || state == ST_PULSE)
            |-> !por_flag;
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("power-on flag survived other reset");
    property p_flash;
        flash_err && !supply_bad |=> state == ST_PULSE ##1 !core.core_run;
    endproperty
    a_flash: assert property (p_flash)
        else $error("flash error reset missing");
    property p_pin;
        state == ST_HOLD |=> rst_pin_oe && !rst_pin_o;
    endproperty
    a_pin: assert property (p_pin)
        else $error("reset pin not driven low");
    property p_keep_en;
        state == ST_PULSE |=> $stable(std_mon_en) && $stable(std_sel);
    endproperty
    a_keep_en: assert property (p_keep_en)
        else $error("monitor state changed by reset");
    property p_port;
        !core.core_run |-> core.port_latch == CORE_RST.port_latch
            && core.weak_pullup && core.fetch_addr == CORE_RST.fetch_addr;
    endproperty
    a_port: assert property (p_port)
        else $error("port or fetch state wrong in reset");
    c_por: cover property (state == ST_POR_DELAY ##1 state == ST_RUN);
    c_hold: cover property (state == ST_RUN ##1 state == ST_HOLD);
    c_flash: cover property (flash_err ##1 state == ST_PULSE);
    c_sw: cover property (sw_rst ##1 state == ST_PULSE);

endmodule

// File: verif/rss_supply_model.sv
// Supply rail comparators and reset pin wiring around the sequencer
`timescale 1ns/10ps
module rss_supply_model (
    // Rail state chosen by the bench
    input  wire logic std_good,
    input  wire logic lvl_good,
    // Comparator outputs, asynchronous to the clock
    output logic      std_vdd_ok,
    output logic      lvl_vdd_ok,
    // Reset pin, open drain with a board pullup
    input  wire logic rst_pin_o,
    input  wire logic rst_pin_oe,
    output logic      pin
);
    // Analog delay keeps comparator edges off the clock edge
    assign #3 std_vdd_ok = std_good;
    assign #3 lvl_vdd_ok = lvl_good;
    // Released pin floats up to the pullup level
    assign pin = rst_pin_oe ? rst_pin_o : 1'b1;
endmodule

// File: verif/rss_reset_seq_tb.sv
// Self-checking bench for the reset sequencer and supply monitors
`timescale 1ns/10ps
module reset_source_supply_monitor_tb;
    import rss_pkg::*;
    localparam int POR   = 20;    // Shortened power-on delay
    localparam int LIMIT = 20000; // Hang ceiling in cycles
    logic        aclk, aresetn, std_good, lvl_good, flash_req;
    logic        std_vdd_ok, lvl_vdd_ok, rst_pin_o, rst_pin_oe, pin;
    logic        std_mon_en, std_hi_sel, lvl_mon_en;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0]  wstrb, strb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [1:0]  bresp, rresp, rs;
    rss_core_t   core;
    int          err_total = 0, n_checks = 0, cyc = 0, n;

    rss_reset_seq #(.POR_CYC(POR)) rss_reset_seq_i (
        .aclk, .aresetn, .std_vdd_ok, .lvl_vdd_ok, .std_mon_en,
        .std_hi_sel, .lvl_mon_en, .flash_req, .core, .rst_pin_o,
        .rst_pin_oe, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready);

    rss_supply_model rss_supply_model_i (
        .std_good, .lvl_good, .std_vdd_ok, .lvl_vdd_ok, .rst_pin_o,
        .rst_pin_oe, .pin);

    // Free-running 100 MHz clock
    always #5 aclk = ~aclk;

    // Hang guard
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_total++;
            complete_run();
        end
    end

    task automatic chk(input string nm, input logic [63:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // Write: offer both channels, drop each once taken, wait for b
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= strb;
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        rs = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // Count edges until the core run flag reaches a level
    task automatic wait_run(input logic lvl, output int k);
        k = 0;
        while (core.core_run !== lvl && k < 2000) begin
            @(posedge aclk);
            k++;
        end
        chk("run_wait", core.core_run, lvl);
    endtask

    task automatic pulse_flash();
        @(posedge aclk);
        flash_req <= 1'b1;
        @(posedge aclk);
        flash_req <= 1'b0;
    endtask

    // Supply low after release: wait for it, then the delay
    task automatic t_power_up();
        repeat (30) @(posedge aclk);
        chk("run_low", core.core_run, 0);
        chk("pin_low", pin, 0);
        chk("core_rst", 64'(core), 64'(CORE_RST));
        lvl_good <= 1'b1;
        wait_run(1, n);
        chk("por_delay", n >= POR && n <= POR + 8, 1);
        repeat (2) @(posedge aclk);
        chk("pin_free", pin, 1);
        chk("mon_en", {std_mon_en, lvl_mon_en}, 2'b11);
        chk("core_exit", {core.pc_clear, core.irq_tmr_off, core.wdt_en,
            core.int_osc_sel}, 4'b0011);
        axi_rd(ADDR_CTRL);
        chk("ctrl", rd, 32'h0000_00d0);
        axi_rd(ADDR_CAUSE);
        chk("por_flag", rd[CAUSE_POR_BIT], 1);
    endtask

    // Unmapped places answer with an error and change nothing
    task automatic t_bad_addr();
        axi_rd(8'h08);
        chk("rd_err", {rs, rd}, {RESP_SLVERR, 32'h0000_0000});
        axi_wr(8'h0c, 32'h0000_0000);
        chk("wr_err", rs, RESP_SLVERR);
        // Write with byte lane 0 off must leave the monitor enabled
        strb = 4'h0;
        axi_wr(ADDR_CTRL, 32'h0000_0000);
        strb = 4'hf;
        chk("strb_off", rs, RESP_OKAY);
        axi_rd(ADDR_CTRL);
        chk("ctrl_kept", rd, 32'h0000_00d0);
    endtask

    // Flash write with the low threshold forces a short reset
    task automatic t_flash_err();
        pulse_flash();
        wait_run(0, n);
        chk("fle_core", 64'(core), 64'(CORE_RST));
        chk("fle_pin", pin, 1);
        wait_run(1, n);
        axi_rd(ADDR_CAUSE);
        chk("fle_cause", rd & 32'h0000_0052, 32'h0000_0040);
    endtask

    // Level monitor brownout releases without the power-on delay
    task automatic t_brownout();
        lvl_good <= 1'b0;
        wait_run(0, n);
        chk("bo_fast", n <= 8, 1);
        repeat (40) @(posedge aclk);
        chk("bo_hold", {core.core_run, pin}, 2'b00);
        lvl_good <= 1'b1;
        wait_run(1, n);
        chk("bo_nodelay", n < POR, 1);
        axi_rd(ADDR_CTRL);
        chk("bo_ctrl", rd, 32'h0000_00d0);
    endtask

    // Software reset keeps the monitor off; then re-enable it
    task automatic t_sw_reset();
        axi_wr(ADDR_CTRL, 32'h0000_0000);
        axi_wr(ADDR_CAUSE, 32'h0000_0012);
        wait_run(0, n);
        wait_run(1, n);
        axi_rd(ADDR_CTRL);
        chk("sw_ctrl", rd, 32'h0000_0050);
        axi_rd(ADDR_CAUSE);
        chk("sw_cause", rd & 32'h0000_0052, 32'h0000_0010);
        std_good <= 1'b0;
        repeat (10) @(posedge aclk);
        chk("std_off", core.core_run, 1);
        std_good <= 1'b1;
        axi_wr(ADDR_CTRL, 32'h0000_0080);
        repeat (20) @(posedge aclk);
        axi_wr(ADDR_CAUSE, 32'h0000_0002);
        repeat (5) @(posedge aclk);
        chk("sel_quiet", core.core_run, 1);
        std_good <= 1'b0;
        wait_run(0, n);
        repeat (2) @(posedge aclk);
        chk("std_pin", pin, 0);
        std_good <= 1'b1;
        wait_run(1, n);
    endtask

    // High threshold selected: flash writes run without reset
    task automatic t_flash_ok();
        axi_wr(ADDR_CTRL, 32'h0000_00a0);
        pulse_flash();
        repeat (20) @(posedge aclk);
        chk("fl_ok", core.core_run, 1);
        axi_rd(ADDR_CTRL);
        chk("hi_ctrl", rd, 32'h0000_00f0);
        chk("hi_pin", std_hi_sel, 1);
        // Software reset drops the threshold but keeps the enable
        axi_wr(ADDR_CAUSE, 32'h0000_0012);
        wait_run(0, n);
        wait_run(1, n);
        chk("hi_clr", std_hi_sel, 0);
        axi_rd(ADDR_CTRL);
        chk("rst_ctrl", rd, 32'h0000_00d0);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Main sequence: reset held low 12 cycles, supply still down
    initial begin
        {aclk, aresetn, lvl_good, flash_req} = '0;
        std_good = 1'b1;
        strb = 4'hf;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_power_up();
        t_bad_addr();
        t_flash_err();
        t_brownout();
        t_sw_reset();
        t_flash_ok();
        complete_run();
    end
endmodule
